// >>> xtp_cpu_end.sv
// CPU end of the extension unit transfer port: hands a decoded template to the
// unit, then runs the word or byte transfers between the unit and memory,
// the general registers or the flag byte.
// Assumes the decoder supplies template, count, base register and effective
// address, and that the register file reads combinationally.
// What this block does
// - Forward enabled templates, never touch operands.
// - Ignore unit-specific opcode bits.
// - Two low bits pick one unit.
// - Unit exceptions arrive as interrupt request.
// - Memory store: CPU addresses, unit supplies.
// - Memory load: CPU addresses, unit captures.
// - Count code plus one transfers.
// - Odd immediate bytes padded to words.
// - Word registers wrap R15 to R0.
// - Longword registers wrap RR30 to RR0.
// - Odd longword load leaves low half.
// - Seven templates, one without transfers.
// - Odd longword send skips last low.
// - Flag load keeps control bits 1..0.
// - Flag byte sent unchanged.
`timescale 1ns/1ps
module xtp_cpu_end
    import xtp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    xtp_link_if.cpu          link,
    input  wire logic        start,
    input  xtp_tmpl_t        tmpl,
    input  wire logic [15:0] first_word,
    input  wire logic [3:0]  cnt_code,
    input  wire logic        word_size,
    input  wire logic        longword,
    input  wire logic [4:0]  base_reg,
    input  wire logic [31:0] eff_addr,
    input  wire logic [15:0] fcw_in,
    output logic      [4:0]  rf_raddr,
    input  wire logic [15:0] rf_rdata,
    output logic             rf_we,
    output logic      [4:0]  rf_waddr,
    output logic      [15:0] rf_wdata,
    output logic             mem_req,
    output logic             mem_we,
    output logic      [31:0] mem_addr,
    output logic      [15:0] mem_wdata,
    input  wire logic [15:0] mem_rdata,
    input  wire logic        mem_ack,
    output logic             fcw_we,
    output logic      [15:0] fcw_wdata,
    output logic             ext_trap,
    output logic             busy,
    output logic             done,
    output logic      [4:0]  imm_words,
    output logic             irq_req
);
    import xtp_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_GET  = 3'h1,
        ST_WAIT = 3'h2,
        ST_PUT  = 3'h3,
        ST_PUTW = 3'h4
    } xtp_cpu_state_t;

    xtp_cpu_state_t state_q;
    xtp_tmpl_t      tmpl_q;
    logic [3:0]     left_q;
    logic [4:0]     idx_q;
    logic           long_q;
    logic           wsize_q;
    logic [15:0]    data_q;
    logic           cmd_vld_q;
    logic [15:0]    cmd_word_q;
    logic [3:0]     cmd_cnt_q;
    logic           c2e_vld_q;
    logic [15:0]    c2e_data_q;
    logic           e2c_req_q;
    logic           src_ext;
    logic           src_mem;
    logic           dst_ext;
    logic           dst_mem;
    logic           last;
    logic [4:0]     reg_idx;
    logic [4:0]     cnt_plus;

    assign link.cmd_vld  = cmd_vld_q;
    assign link.cmd_word = cmd_word_q;
    assign link.cmd_tmpl = tmpl_q;
    assign link.cmd_cnt  = cmd_cnt_q;
    assign link.c2e_vld  = c2e_vld_q;
    assign link.c2e_data = c2e_data_q;
    assign link.e2c_req  = e2c_req_q;
    assign irq_req = link.irq;

    assign src_ext = (tmpl_q == TPL_MEM_FROM_EXT) || (tmpl_q == TPL_REG_FROM_EXT)
                     || (tmpl_q == TPL_FLAGS_FROM_EXT);
    assign src_mem = (tmpl_q == TPL_EXT_FROM_MEM);
    assign dst_ext = !src_ext;
    assign dst_mem = (tmpl_q == TPL_MEM_FROM_EXT);
    assign last    = (left_q == 4'h0);
    assign busy    = (state_q != ST_IDLE);
    assign cnt_plus = {1'b0, cnt_code} + 5'h01;

    // Word registers wrap in four bits.
    // Longword halves wrap in five bits.
    assign reg_idx  = long_q ? idx_q : {1'b0, idx_q[3:0]};
    assign rf_raddr = reg_idx;

    // Instruction length helper for the immediate form of a memory load.
    // Round odd byte count up.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imm_words <= 5'h00;
        end else if (ce && start && state_q == ST_IDLE) begin
            if (tmpl != TPL_EXT_FROM_MEM) begin
                imm_words <= 5'h00;
            end else if (word_size) begin
                imm_words <= cnt_plus;
            end else begin
                imm_words <= 5'((cnt_plus + 5'h01) >> 1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_trap <= 1'b0;
        end else if (ce) begin
            ext_trap <= start && state_q == ST_IDLE && !fcw_in[EXT_ARCH_BIT];
        end
    end

    // Sequencer; pulses default low so each lasts one enabled cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= ST_IDLE;
            tmpl_q     <= TPL_INTERNAL;
            left_q     <= 4'h0;
            idx_q      <= 5'h00;
            long_q     <= 1'b0;
            wsize_q    <= 1'b0;
            data_q     <= 16'h0000;
            cmd_vld_q  <= 1'b0;
            cmd_word_q <= 16'h0000;
            cmd_cnt_q  <= 4'h0;
            c2e_vld_q  <= 1'b0;
            c2e_data_q <= 16'h0000;
            e2c_req_q  <= 1'b0;
            rf_we      <= 1'b0;
            rf_waddr   <= 5'h00;
            rf_wdata   <= 16'h0000;
            mem_req    <= 1'b0;
            mem_we     <= 1'b0;
            mem_addr   <= 32'h0000_0000;
            mem_wdata  <= 16'h0000;
            fcw_we     <= 1'b0;
            fcw_wdata  <= 16'h0000;
            done       <= 1'b0;
        end else if (ce) begin
            cmd_vld_q <= 1'b0;
            c2e_vld_q <= 1'b0;
            e2c_req_q <= 1'b0;
            rf_we     <= 1'b0;
            fcw_we    <= 1'b0;
            done      <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (start && !fcw_in[EXT_ARCH_BIT]) begin
                        done <= 1'b1;
                    end else if (start) begin
                        cmd_vld_q  <= 1'b1;
                        cmd_word_q <= first_word;
                        cmd_cnt_q  <= cnt_code;
                        tmpl_q     <= tmpl;
                        // Count code is n minus one.
                        left_q     <= cnt_code;
                        idx_q      <= base_reg;
                        long_q     <= longword;
                        wsize_q    <= word_size;
                        mem_addr   <= eff_addr;
                        if (tmpl == TPL_INTERNAL) begin
                            done <= 1'b1;
                        end else begin
                            state_q <= ST_GET;
                        end
                    end
                end
                ST_GET: begin
                    if (src_ext) begin
                        e2c_req_q <= 1'b1;
                        state_q   <= ST_WAIT;
                    end else if (src_mem) begin
                        mem_req <= 1'b1;
                        mem_we  <= 1'b0;
                        state_q <= ST_WAIT;
                    end else if (tmpl_q == TPL_EXT_FROM_REG) begin
                        data_q  <= rf_rdata;
                        state_q <= ST_PUT;
                    end else begin
                        data_q  <= {8'h00, fcw_in[7:0]};
                        state_q <= ST_PUT;
                    end
                end
                ST_WAIT: begin
                    if (src_ext && link.e2c_vld) begin
                        data_q  <= link.e2c_data;
                        state_q <= ST_PUT;
                    end else if (src_mem && mem_ack) begin
                        mem_req <= 1'b0;
                        data_q  <= wsize_q ? mem_rdata : {8'h00, mem_rdata[7:0]};
                        state_q <= ST_PUT;
                    end
                end
                ST_PUT: begin
                    state_q <= ST_PUTW;
                    if (dst_mem) begin
                        mem_req   <= 1'b1;
                        mem_we    <= 1'b1;
                        mem_wdata <= data_q;
                    end else if (dst_ext) begin
                        c2e_vld_q  <= 1'b1;
                        c2e_data_q <= data_q;
                    end else if (tmpl_q == TPL_REG_FROM_EXT) begin
                        // Odd count never reaches the low half.
                        rf_we    <= 1'b1;
                        rf_waddr <= reg_idx;
                        rf_wdata <= data_q;
                    end else begin
                        fcw_we    <= 1'b1;
                        fcw_wdata <= {fcw_in[15:FLAG_HI+1], data_q[FLAG_HI:FLAG_LO],
                                      fcw_in[FLAG_LO-1:0]};
                    end
                end
                ST_PUTW: begin
                    if (!dst_mem || mem_ack) begin
                        mem_req <= 1'b0;
                        if (last) begin
                            done    <= 1'b1;
                            state_q <= ST_IDLE;
                        end else begin
                            left_q   <= left_q - 4'h1;
                            idx_q    <= idx_q + 5'h01;
                            mem_addr <= mem_addr + (wsize_q ? STEP_WORD : STEP_BYTE);
                            state_q  <= ST_GET;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// >>> xtp_pkg.sv
// Shared constants and types for the extension unit transfer port.
// Assumes both ends run on the same pclk and presetn.
package xtp_pkg;

    // Position of the extended-architecture enable bit in the flag/control word.
    localparam int unsigned EXT_ARCH_BIT = 4;
    // Flag byte of the flag/control word; bits 1..0 are control and never loaded.
    localparam int unsigned FLAG_LO      = 2;
    localparam int unsigned FLAG_HI      = 7;

    localparam logic [31:0] STEP_BYTE    = 32'h0000_0001;
    localparam logic [31:0] STEP_WORD    = 32'h0000_0002;

    // Register map of the extension unit end, byte addresses.
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_STAT     = 8'h04;
    localparam logic [7:0]  OFS_MASK     = 8'h08;
    localparam int unsigned STAT_EXC     = 0;
    localparam int unsigned STAT_CMD     = 1;
    localparam int unsigned STAT_W       = 2;
    localparam logic [1:0]  UNIT_ID_RST  = 2'h0;
    localparam logic [1:0]  STAT_RST     = 2'h0;
    localparam logic [1:0]  MASK_RST     = 2'h0;

    typedef enum logic [2:0] {
        TPL_MEM_FROM_EXT   = 3'h0,
        TPL_EXT_FROM_MEM   = 3'h1,
        TPL_REG_FROM_EXT   = 3'h2,
        TPL_EXT_FROM_REG   = 3'h3,
        TPL_FLAGS_FROM_EXT = 3'h4,
        TPL_EXT_FROM_FLAGS = 3'h5,
        TPL_INTERNAL       = 3'h6
    } xtp_tmpl_t;

endpackage

// >>> xtp_link_if.sv
// Link between the CPU end and the extension unit end.
// Assumes one clock; all signals are sampled on the rising edge of pclk.
`timescale 1ns/1ps
interface xtp_link_if;
    import xtp_pkg::*;
    logic            cmd_vld;
    logic [15:0]     cmd_word;
    xtp_tmpl_t       cmd_tmpl;
    logic [3:0]      cmd_cnt;
    logic            c2e_vld;
    logic [15:0]     c2e_data;
    logic            e2c_req;
    logic            e2c_vld;
    logic [15:0]     e2c_data;
    logic            irq;

    modport cpu (
        output cmd_vld, cmd_word, cmd_tmpl, cmd_cnt, c2e_vld, c2e_data, e2c_req,
        input  e2c_vld, e2c_data, irq
    );
    modport epu (
        input  cmd_vld, cmd_word, cmd_tmpl, cmd_cnt, c2e_vld, c2e_data, e2c_req,
        output e2c_vld, e2c_data, irq
    );
endinterface

// >>> xtp_epu_end.sv
// Extension unit end: takes templates addressed to its identifier, moves data
// to and from its processing core, and raises the CPU interrupt on exceptions.
// Assumes an APB master on the register side and a core that keeps dout valid.
`timescale 1ns/1ps
module xtp_epu_end
    import xtp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    xtp_link_if.epu          link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             op_vld,
    output logic      [15:0] op_word,
    output xtp_tmpl_t        op_tmpl,
    output logic      [3:0]  op_cnt,
    output logic             din_vld,
    output logic      [15:0] din,
    input  wire logic [15:0] dout,
    output logic             dout_take,
    input  wire logic        core_exc
);
    import xtp_pkg::*;

    logic [1:0]  unit_id_q;
    logic [1:0]  stat_q;
    logic [1:0]  mask_q;
    logic        sel_q;
    logic        e2c_vld_q;
    logic [15:0] e2c_data_q;
    logic        wr_en;
    logic        mine;
    logic [1:0]  ev;

    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite && ce;
    assign mine    = link.cmd_vld && (link.cmd_word[1:0] == unit_id_q);
    assign ev      = {mine, core_exc};
    assign link.e2c_vld  = e2c_vld_q;
    assign link.e2c_data = e2c_data_q;
    assign link.irq = |(stat_q & mask_q);

    always_comb begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        unique case (paddr)
            OFS_CTRL: prdata = {30'h0, unit_id_q};
            OFS_STAT: prdata = {30'h0, stat_q};
            OFS_MASK: prdata = {30'h0, mask_q};
            default:  pslverr = psel && penable;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_id_q <= UNIT_ID_RST;
            mask_q    <= MASK_RST;
        end else if (wr_en) begin
            if (paddr == OFS_CTRL) begin
                unit_id_q <= pwdata[1:0];
            end
            if (paddr == OFS_MASK) begin
                mask_q <= pwdata[STAT_W-1:0];
            end
        end
    end

    // Events win over a write-one-to-clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= STAT_RST;
        end else if (ce) begin
            for (int i = 0; i < STAT_W; i++) begin
                if (ev[i]) begin
                    stat_q[i] <= 1'b1;
                end else if (wr_en && paddr == OFS_STAT && pwdata[i]) begin
                    stat_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q   <= 1'b0;
            op_vld  <= 1'b0;
            op_word <= 16'h0000;
            op_tmpl <= TPL_INTERNAL;
            op_cnt  <= 4'h0;
        end else if (ce) begin
            op_vld <= mine;
            if (link.cmd_vld) begin
                sel_q <= mine;
            end
            if (mine) begin
                op_word <= link.cmd_word;
                op_tmpl <= link.cmd_tmpl;
                op_cnt  <= link.cmd_cnt;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_vld    <= 1'b0;
            din        <= 16'h0000;
            e2c_vld_q  <= 1'b0;
            e2c_data_q <= 16'h0000;
            dout_take  <= 1'b0;
        end else if (ce) begin
            din_vld   <= link.c2e_vld && sel_q;
            e2c_vld_q <= link.e2c_req && sel_q;
            dout_take <= link.e2c_req && sel_q;
            if (link.c2e_vld && sel_q) begin
                din <= link.c2e_data;
            end
            if (link.e2c_req && sel_q) begin
                e2c_data_q <= dout;
            end
        end
    end

endmodule

// >>> xtp_link_properties.sv
// Concurrent checks on the link that joins the CPU end to the extension unit end.
// Assumes ce stays high, so every link pulse lasts exactly one pclk cycle.
`timescale 1ns/1ps
module xtp_link_properties (
    input logic               pclk,
    input logic               presetn,
    input logic               cmd_vld,
    input xtp_pkg::xtp_tmpl_t cmd_tmpl,
    input logic [3:0]         cmd_cnt,
    input logic               c2e_vld,
    input logic [15:0]        c2e_data,
    input logic               e2c_req,
    input logic               e2c_vld
);
    import xtp_pkg::*;
    logic [4:0] left_q;
    logic [4:0] left_d;
    logic       to_cpu_q;
    xtp_tmpl_t  tmpl_q;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Transfers still owed by the current template; flag templates move one word.
    always_comb begin
        left_d = left_q;
        if (cmd_vld) begin
            left_d = (cmd_tmpl == TPL_INTERNAL) ? 5'h00 :
                     (cmd_tmpl inside {TPL_FLAGS_FROM_EXT, TPL_EXT_FROM_FLAGS}) ? 5'h01 :
                     {1'b0, cmd_cnt} + 5'h01;
        end else if (c2e_vld || e2c_vld) begin
            left_d = left_q - 5'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_q   <= 5'h00;
            to_cpu_q <= 1'b0;
            tmpl_q   <= TPL_INTERNAL;
        end else begin
            left_q <= left_d;
            if (cmd_vld) begin
                tmpl_q   <= cmd_tmpl;
                to_cpu_q <= cmd_tmpl inside {TPL_MEM_FROM_EXT, TPL_REG_FROM_EXT, TPL_FLAGS_FROM_EXT};
            end
        end
    end

    a_no_extra_xfer: assert property ((c2e_vld || e2c_vld) |-> left_q != 5'h00)
        else $error("transfer beyond the template count");
    a_count_used_up: assert property (cmd_vld |-> left_q == 5'h00)
        else $error("template started before all transfers of the last one");
    a_dir_from_unit: assert property (e2c_req |-> to_cpu_q && left_q != 5'h00)
        else $error("word requested from the unit in the wrong template");
    a_dir_to_unit: assert property (c2e_vld |-> !to_cpu_q)
        else $error("data sent to the unit in a template that reads from it");
    a_flag_byte_only: assert property (c2e_vld && tmpl_q == TPL_EXT_FROM_FLAGS |-> c2e_data[15:8] == 8'h00)
        else $error("flag byte sent with upper bits set");
    a_reply_follows: assert property (e2c_vld |-> $past(e2c_req))
        else $error("unit answered without a request");
    a_req_spacing: assert property (e2c_req |=> (!e2c_req) [*2])
        else $error("word requests closer than the transfer walk allows");
    a_send_pulse: assert property (c2e_vld |=> !c2e_vld)
        else $error("send strobe held longer than one cycle");
endmodule

// >>> xtp_tb_top.sv
// Testbench joining both ends of the transfer port through the link interface.
// Assumes one 20 MHz clock; memory, register file and core are simple models here.
`timescale 1ns/1ps
module xtp_tb_top;
    import xtp_pkg::*;
    typedef struct packed {
        xtp_tmpl_t  t;
        logic [3:0] c;
        logic       ws;
        logic       lw;
        logic [4:0] b;
    } xtp_row_t;
    logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, start = 1'b0, word_size = 1'b0;
    logic        longword = 1'b0, mem_ack = 1'b0, core_exc = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        rf_we, mem_req, mem_we, fcw_we, ext_trap, busy, done, irq_req;
    logic        pready, pslverr, op_vld, din_vld, dout_take;
    xtp_tmpl_t   tmpl = TPL_INTERNAL, op_tmpl;
    logic [3:0]  cnt_code = 4'h0, op_cnt;
    logic [4:0]  base_reg = 5'h00, rf_raddr, rf_waddr, imm_words;
    logic [7:0]  paddr = 8'h00;
    logic [15:0] first_word = 16'hfa02, fcw_in = 16'hb7d3, seq = 16'h0000, s0;
    logic [15:0] rf_rdata, mem_rdata, dout, rf_wdata, mem_wdata, fcw_wdata, op_word, din;
    logic [31:0] eff_addr = 32'h0001_0ff8, pwdata = 32'h0, mem_addr, prdata;
    logic [31:0] mw_a[$];
    logic [15:0] mw_d[$], din_q[$], rfw_d[$], fcw_q[$];
    logic [4:0]  rfw_a[$];
    int          n_mismatch = 0, tests_run = 0, n_op = 0, n_trap = 0;
    xtp_row_t    rows [12] = '{
        '{TPL_MEM_FROM_EXT, 4'h0, 1'b1, 1'b0, 5'h00}, '{TPL_MEM_FROM_EXT, 4'hf, 1'b1, 1'b0, 5'h00},
        '{TPL_MEM_FROM_EXT, 4'h2, 1'b0, 1'b0, 5'h00}, '{TPL_EXT_FROM_MEM, 4'h2, 1'b0, 1'b0, 5'h00},
        '{TPL_EXT_FROM_MEM, 4'h3, 1'b1, 1'b0, 5'h00}, '{TPL_REG_FROM_EXT, 4'h3, 1'b0, 1'b0, 5'h0e},
        '{TPL_REG_FROM_EXT, 4'h2, 1'b0, 1'b1, 5'h1e}, '{TPL_EXT_FROM_REG, 4'h3, 1'b0, 1'b0, 5'h0f},
        '{TPL_EXT_FROM_REG, 4'h2, 1'b0, 1'b1, 5'h1e}, '{TPL_FLAGS_FROM_EXT, 4'h0, 1'b0, 1'b0, 5'h00},
        '{TPL_EXT_FROM_FLAGS, 4'h0, 1'b0, 1'b0, 5'h00}, '{TPL_INTERNAL, 4'h0, 1'b0, 1'b0, 5'h00}};

    xtp_link_if xtp_link_if_i ();
    xtp_cpu_end xtp_cpu_end_i (.pclk(pclk), .presetn(presetn), .ce(ce), .link(xtp_link_if_i),
        .start(start), .tmpl(tmpl), .first_word(first_word), .cnt_code(cnt_code),
        .word_size(word_size), .longword(longword), .base_reg(base_reg), .eff_addr(eff_addr),
        .fcw_in(fcw_in), .rf_raddr(rf_raddr), .rf_rdata(rf_rdata), .rf_we(rf_we),
        .rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .fcw_we(fcw_we), .fcw_wdata(fcw_wdata), .ext_trap(ext_trap), .busy(busy), .done(done),
        .imm_words(imm_words), .irq_req(irq_req));
    xtp_epu_end xtp_epu_end_i (.pclk(pclk), .presetn(presetn), .ce(ce), .link(xtp_link_if_i),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_vld(op_vld), .op_word(op_word),
        .op_tmpl(op_tmpl), .op_cnt(op_cnt), .din_vld(din_vld), .din(din), .dout(dout),
        .dout_take(dout_take), .core_exc(core_exc));
    xtp_link_properties xtp_link_properties_i (.pclk(pclk), .presetn(presetn),
        .cmd_vld(xtp_link_if_i.cmd_vld), .cmd_tmpl(xtp_link_if_i.cmd_tmpl),
        .cmd_cnt(xtp_link_if_i.cmd_cnt), .c2e_vld(xtp_link_if_i.c2e_vld),
        .c2e_data(xtp_link_if_i.c2e_data), .e2c_req(xtp_link_if_i.e2c_req),
        .e2c_vld(xtp_link_if_i.e2c_vld));

    // Register file and memory answer from the address, so expectations need no storage.
    assign rf_rdata  = 16'h1000 + {11'h000, rf_raddr};
    assign mem_rdata = mem_addr[15:0] ^ 16'h5a5a;
    assign dout      = 16'hc300 + seq;

    initial begin
        forever #25 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    always @(posedge pclk) begin
        mem_ack <= mem_req && !mem_ack;
        if (dout_take === 1'b1) seq <= seq + 16'h0001;
        if (mem_req === 1'b1 && mem_ack === 1'b1 && mem_we === 1'b1) begin
            mw_a.push_back(mem_addr);
            mw_d.push_back(mem_wdata);
        end
        if (din_vld === 1'b1) din_q.push_back(din);
        if (rf_we === 1'b1) begin
            rfw_a.push_back(rf_waddr);
            rfw_d.push_back(rf_wdata);
        end
        if (fcw_we === 1'b1) fcw_q.push_back(fcw_wdata);
        if (ext_trap === 1'b1) n_trap++;
        if (op_vld === 1'b1) begin
            n_op++;
            chk(op_word, first_word);
            chk(op_tmpl, tmpl);
            chk(op_cnt, cnt_code);
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic run(input xtp_row_t r);
        mw_a = {};
        mw_d = {};
        din_q = {};
        rfw_a = {};
        rfw_d = {};
        fcw_q = {};
        n_op = 0;
        n_trap = 0;
        s0 = seq;
        start     <= 1'b1;
        tmpl      <= r.t;
        cnt_code  <= r.c;
        word_size <= r.ws;
        longword  <= r.lw;
        base_reg  <= r.b;
        @(posedge pclk);
        start <= 1'b0;
        for (int k = 0; k < 400; k++) begin
            @(posedge pclk);
            if (done === 1'b1) break;
            if (k == 399) n_mismatch++;
        end
        // Internal templates raise op_vld a cycle after done.
        repeat (2) @(posedge pclk);
    endtask

    task automatic close_out;
        $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        close_out;
    end

    initial begin
        xtp_row_t    r;
        int          n;
        logic [15:0] m;
        logic [15:0] ev;
        logic [31:0] ad;
        logic [31:0] rd;
        logic [4:0]  ix;
        logic        er;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_MASK, 32'h0, rd, er);
        chk(rd, {30'h0, MASK_RST});
        apb(1'b1, OFS_CTRL, 32'h2, rd, er);
        apb(1'b0, OFS_CTRL, 32'h0, rd, er);
        chk(rd[1:0], 2'h2);
        for (int i = 0; i < 12; i++) begin
            r = rows[i];
            n = r.c + 1;
            m = r.ws ? 16'hffff : 16'h00ff;
            run(r);
            chk(n_op, 1);
            chk(mw_a.size(), (r.t == TPL_MEM_FROM_EXT) ? n : 0);
            chk(din_q.size(), (r.t inside {TPL_EXT_FROM_MEM, TPL_EXT_FROM_REG}) ? n :
                (r.t == TPL_EXT_FROM_FLAGS) ? 1 : 0);
            chk(rfw_a.size(), (r.t == TPL_REG_FROM_EXT) ? n : 0);
            chk(fcw_q.size(), (r.t == TPL_FLAGS_FROM_EXT) ? 1 : 0);
            chk(imm_words, (r.t == TPL_EXT_FROM_MEM) ? (r.ws ? n : (n + 1) / 2) : 0);
            for (int j = 0; j < n; j++) begin
                ad = eff_addr + j * (r.ws ? 2 : 1);
                ev = 16'hc300 + s0 + j;
                ix = r.b + j[4:0];
                ix[4] = ix[4] & r.lw;
                if (r.t == TPL_MEM_FROM_EXT) begin
                    chk(mw_a[j], ad);
                    chk(mw_d[j] & m, ev & m);
                end
                if (r.t == TPL_EXT_FROM_MEM) chk(din_q[j] & m, (ad[15:0] ^ 16'h5a5a) & m);
                if (r.t == TPL_REG_FROM_EXT) begin
                    chk(rfw_a[j], ix);
                    chk(rfw_d[j], ev);
                end
                if (r.t == TPL_EXT_FROM_REG) chk(din_q[j], 16'h1000 + ix);
                if (r.t == TPL_FLAGS_FROM_EXT) chk(fcw_q[0], {fcw_in[15:8], ev[7:2], fcw_in[1:0]});
                if (r.t == TPL_EXT_FROM_FLAGS) chk(din_q[0], {8'h00, fcw_in[7:0]});
            end
        end
        // Enable bit clear: the template must trap and never reach the unit.
        fcw_in <= 16'hb7c3;
        run(rows[0]);
        chk(n_trap, 1);
        chk(n_op + mw_a.size(), 0);
        fcw_in     <= 16'hb7d3;
        first_word <= 16'hfa01;
        run(rows[11]);
        chk(n_op, 0);
        first_word <= 16'hfa02;
        run(rows[0]);
        chk(n_op, 1);
        apb(1'b1, OFS_MASK, 32'h1, rd, er);
        chk(irq_req, 1'b0);
        core_exc <= 1'b1;
        @(posedge pclk);
        core_exc <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(irq_req, 1'b1);
        apb(1'b0, OFS_STAT, 32'h0, rd, er);
        chk(rd, 32'h3);
        apb(1'b1, OFS_STAT, 32'h3, rd, er);
        chk(irq_req, 1'b0);
        apb(1'b0, 8'h0c, 32'h0, rd, er);
        chk(er, 1'b1);
        // A low clock enable must block register writes as well.
        ce <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h1, rd, er);
        ce <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0, rd, er);
        chk(rd[1:0], 2'h2);
        // A reset in mid-transfer must leave busy, mem_req and irq_req low two cycles later.
        start <= 1'b1;
        tmpl  <= TPL_MEM_FROM_EXT;
        cnt_code <= 4'hf;
        @(posedge pclk);
        start <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({busy, mem_req, irq_req}, 3'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        close_out;
    end
endmodule
